//--- design/bfp_port_ctrl.sv
// Notes on behaviour
// RULE_01: port b moves data on b clock rises
// RULE_02: port b flags change on b rises only
// RULE_03: port a access needs chip select low
// RULE_04: port a data floats while deselected
// RULE_05: port b access needs chip select low
// RULE_06: port b data floats while deselected
// RULE_07: port a enable high qualifies each access
// RULE_08: port b enable high qualifies each access
// RULE_09: standard mode: port a empty flag
// RULE_10: fall-through mode: port a output ready
// RULE_11: standard mode: port b empty flag
// RULE_12: fall-through mode: port b output ready
// RULE_13: standard mode: port a full flag
// RULE_14: fall-through mode: port a input ready
// RULE_15: standard mode: port b full flag
// RULE_16: fall-through mode: port b input ready
// RULE_17: port a flags change on a rises only
// RULE_18: strap after reset picks flag timing
// RULE_19: empty/full low active, ready high active
`timescale 1ns/1ps

// simple flip-flop queue with valid/ready on both sides
module bfp_queue #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	// words currently held
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	// whole queue state, storage included
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
	} bfp_queue_s;

	bfp_queue_s q_q;
	bfp_queue_s q_d;
	logic push;
	logic pop;

	// honest flags straight from the count
	assign inReady = (q_q.count != (AW+1)'(DEPTH));
	assign outValid = (q_q.count != '0);
	assign outData = q_q.mem[q_q.rdPtr];
	assign level = q_q.count;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// next state: write at head, read at tail
	always_comb
	begin
		q_d = q_q;
		if (push)
		begin
			q_d.mem[q_q.wrPtr] = inData;
			// wraps naturally since depth is a power of two
			q_d.wrPtr = q_q.wrPtr + AW'(1);
		end
		if (pop)
		begin
			q_d.rdPtr = q_q.rdPtr + AW'(1);
		end
		q_d.count = q_q.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_q <= '0;
		end
		else
		begin
			q_q <= q_d;
		end
	end
endmodule

// two-port queue front end: qualification, data pins and status flags
module bfp_port_ctrl #(
	parameter int DEPTH = bfp_pkg::QUEUE_DEPTH,
	parameter int AE_OFS = bfp_pkg::ALMOST_EMPTY_OFS,
	parameter int AF_OFS = bfp_pkg::ALMOST_FULL_OFS
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// shared timing strap, sampled once after reset
	input wire logic endianTimingSelect,
	// port a control
	input wire logic portAClock,
	input wire logic portAChipSelectN,
	input wire logic portAEnable,
	input wire logic portAWrite,
	// port a data pin, split into three signals
	input wire logic [bfp_pkg::DATA_W-1:0] portADataIn,
	output logic [bfp_pkg::DATA_W-1:0] portADataOut,
	output logic portADataOe,
	// port a status
	output logic portAEmptyN,
	output logic portAOutputReady,
	output logic portAFullN,
	output logic portAInputReady,
	// port b control
	input wire logic portBClock,
	input wire logic portBChipSelectN,
	input wire logic portBEnable,
	input wire logic portBWrite,
	// port b data pin, split into three signals
	input wire logic [bfp_pkg::DATA_W-1:0] portBDataIn,
	output logic [bfp_pkg::DATA_W-1:0] portBDataOut,
	output logic portBDataOe,
	// port b status
	output logic portBEmptyN,
	output logic portBOutputReady,
	output logic portBFullN,
	output logic portBInputReady,
	output logic portBAlmostFullN,
	output logic portBAlmostEmptyN
);
	import bfp_pkg::*;

	localparam int LW = $clog2(DEPTH) + 1;

	// all controller state
	typedef struct packed {
		logic aClkPrev;
		logic bClkPrev;
		logic modeTaken;
		logic modeStd;
		logic [DATA_W-1:0] aOut;
		logic aOutValid;
		logic [DATA_W-1:0] bOut;
		logic bOutValid;
		logic aEmptyN;
		logic aOutReady;
		logic aFullN;
		logic aInReady;
		logic bEmptyN;
		logic bOutReady;
		logic bFullN;
		logic bInReady;
		logic bAlmostFullN;
		logic bAlmostEmptyN;
	} bfp_state_s;

	bfp_state_s s_q;
	bfp_state_s s_d;

	// reset image; prev clocks high so a clock high at release is no rise
	localparam bfp_state_s RST_STATE = '{aClkPrev: 1'b1, bClkPrev: 1'b1,
		modeTaken: 1'b0, modeStd: RST_MODE_STD, aOut: RST_DATA,
		aOutValid: 1'b0, bOut: RST_DATA, bOutValid: 1'b0,
		aEmptyN: RST_EMPTY_N, aOutReady: RST_OUT_READY, aFullN: RST_FULL_N,
		aInReady: RST_IN_READY, bEmptyN: RST_EMPTY_N,
		bOutReady: RST_OUT_READY, bFullN: RST_FULL_N,
		bInReady: RST_IN_READY, bAlmostFullN: RST_ALMOST_FULL_N,
		bAlmostEmptyN: RST_ALMOST_EMPTY_N};

	// queue handshakes
	logic abPush, abInReady, abOutValid, abPop;
	logic [DATA_W-1:0] abData;
	logic [LW-1:0] abLevel;
	logic baPush, baInReady, baOutValid, baPop;
	logic [DATA_W-1:0] baData;
	logic [LW-1:0] baLevel;
	// port clock rises seen in the system clock
	logic aEdge, bEdge;
	// qualified accesses
	logic aSel, bSel, aRead, bRead;
	// fall-through prefetch into the output register
	logic aLoad, bLoad;
	// levels once this cycle's moves have landed
	logic [LW-1:0] abNext, baNext;

	// port clocks are synchronous inputs, so a plain compare finds rises
	assign aEdge = portAClock && !s_q.aClkPrev;
	// RULE_01: b clock rise
	assign bEdge = portBClock && !s_q.bClkPrev;

	// RULE_03: chip select low
	// RULE_07: enable qualifies
	assign aSel = aEdge && !portAChipSelectN && portAEnable;
	// RULE_05: chip select low
	// RULE_08: enable qualifies
	assign bSel = bEdge && !portBChipSelectN && portBEnable;

	// writes that meet a full queue are dropped; the full flag warns first
	assign abPush = aSel && portAWrite;
	assign baPush = bSel && portBWrite;

	// standard reads pop directly; fall-through reads take the held word
	assign aRead = aSel && !portAWrite
		&& (s_q.modeStd ? baOutValid : s_q.aOutValid);
	assign bRead = bSel && !portBWrite
		&& (s_q.modeStd ? abOutValid : s_q.bOutValid);

	// fall-through refill happens only on that port's own clock rise
	assign aLoad = !s_q.modeStd && aEdge && (!s_q.aOutValid || aRead)
		&& baOutValid;
	assign bLoad = !s_q.modeStd && bEdge && (!s_q.bOutValid || bRead)
		&& abOutValid;
	assign baPop = s_q.modeStd ? aRead : aLoad;
	assign abPop = s_q.modeStd ? bRead : bLoad;

	assign abNext = abLevel + LW'(abPush && abInReady) - LW'(abPop);
	assign baNext = baLevel + LW'(baPush && baInReady) - LW'(baPop);

	// data pins drive only for a selected read
	// RULE_04: float when deselected
	assign portADataOe = !portAChipSelectN && !portAWrite;
	// RULE_06: float when deselected
	assign portBDataOe = !portBChipSelectN && !portBWrite;
	assign portADataOut = s_q.aOut;
	assign portBDataOut = s_q.bOut;

	// flags straight from their registers
	assign portAEmptyN = s_q.aEmptyN;
	assign portAOutputReady = s_q.aOutReady;
	assign portAFullN = s_q.aFullN;
	assign portAInputReady = s_q.aInReady;
	assign portBEmptyN = s_q.bEmptyN;
	assign portBOutputReady = s_q.bOutReady;
	assign portBFullN = s_q.bFullN;
	assign portBInputReady = s_q.bInReady;
	assign portBAlmostFullN = s_q.bAlmostFullN;
	assign portBAlmostEmptyN = s_q.bAlmostEmptyN;

	// a to b direction
	bfp_queue #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) a_to_b_queue (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inValid(abPush),
		.inReady(abInReady),
		.inData(portADataIn),
		.outValid(abOutValid),
		.outReady(abPop),
		.outData(abData),
		.level(abLevel)
	);

	// b to a direction
	bfp_queue #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) b_to_a_queue (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inValid(baPush),
		.inReady(baInReady),
		.inData(portBDataIn),
		.outValid(baOutValid),
		.outReady(baPop),
		.outData(baData),
		.level(baLevel)
	);

	// next controller state
	always_comb
	begin
		s_d = s_q;
		s_d.aClkPrev = portAClock;
		s_d.bClkPrev = portBClock;
		// RULE_18: strap sampled once
		if (!s_q.modeTaken)
		begin
			// the strap must stay put afterwards; later changes are ignored
			s_d.modeStd = (endianTimingSelect == TIMING_STD);
			s_d.modeTaken = 1'b1;
		end
		// port a output register
		if (s_q.modeStd ? aRead : aLoad)
		begin
			s_d.aOut = baData;
		end
		if (aLoad)
		begin
			s_d.aOutValid = 1'b1;
		end
		else if (aRead && !s_q.modeStd)
		begin
			s_d.aOutValid = 1'b0;
		end
		// port b output register
		if (s_q.modeStd ? bRead : bLoad)
		begin
			s_d.bOut = abData;
		end
		if (bLoad)
		begin
			s_d.bOutValid = 1'b1;
		end
		else if (bRead && !s_q.modeStd)
		begin
			s_d.bOutValid = 1'b0;
		end
		// RULE_17: port a flags on a rise
		if (aEdge)
		begin
			// RULE_19: empty and full low active
			// RULE_09: empty of b to a
			s_d.aEmptyN = (baNext != '0);
			// RULE_10: held word present
			s_d.aOutReady = !s_q.modeStd && s_d.aOutValid;
			// RULE_13: full of a to b
			s_d.aFullN = (abNext != LW'(DEPTH));
			// RULE_14: space in a to b
			s_d.aInReady = (abNext != LW'(DEPTH));
		end
		// RULE_02: port b flags on b rise
		if (bEdge)
		begin
			// RULE_11: empty of a to b
			s_d.bEmptyN = (abNext != '0);
			// RULE_12: held word present
			s_d.bOutReady = !s_q.modeStd && s_d.bOutValid;
			// RULE_15: full of b to a
			s_d.bFullN = (baNext != LW'(DEPTH));
			// RULE_16: space in b to a
			s_d.bInReady = (baNext != LW'(DEPTH));
			// thresholds count queue words only, not the held word
			s_d.bAlmostEmptyN = (abNext > LW'(AE_OFS));
			s_d.bAlmostFullN = ((LW'(DEPTH) - baNext) > LW'(AF_OFS));
		end
	end

	// state register, constants only under reset
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= RST_STATE;
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule

//--- design/bfp_pkg.sv
// shared constants for the two-way queue port block
package bfp_pkg;
	// data path width per port
	localparam int DATA_W = 36;
	// words held by each direction's queue
	localparam int QUEUE_DEPTH = 32;
	// default almost-empty and almost-full thresholds for port b
	localparam int ALMOST_EMPTY_OFS = 8;
	localparam int ALMOST_FULL_OFS = 8;
	// level of the timing strap that selects standard flag timing
	localparam logic TIMING_STD = 1'b1;
	// flag values while in reset: queues empty, space free
	localparam logic RST_EMPTY_N = 1'b0;
	localparam logic RST_OUT_READY = 1'b0;
	localparam logic RST_FULL_N = 1'b1;
	localparam logic RST_IN_READY = 1'b1;
	localparam logic RST_ALMOST_EMPTY_N = 1'b0;
	localparam logic RST_ALMOST_FULL_N = 1'b1;
	// mode assumed until the strap has been sampled
	localparam logic RST_MODE_STD = 1'b1;
	// output data register after reset
	localparam logic [DATA_W-1:0] RST_DATA = 36'h0;
endpackage

//--- sim/bfp_port_ctrl_props.sv
`timescale 1ns/1ps
// pin-level checks on the two-way queue front end
module bfp_port_ctrl_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// strap and port a
	input wire logic endianTimingSelect,
	input wire logic portAClock,
	input wire logic portAChipSelectN,
	input wire logic portAEnable,
	input wire logic portADataOe,
	input wire logic portAEmptyN,
	input wire logic portAOutputReady,
	input wire logic portAFullN,
	input wire logic portAInputReady,
	// port b
	input wire logic portBClock,
	input wire logic portBChipSelectN,
	input wire logic portBEnable,
	input wire logic portBDataOe,
	input wire logic [bfp_pkg::DATA_W-1:0] portBDataOut,
	input wire logic portBEmptyN,
	input wire logic portBOutputReady,
	input wire logic portBFullN,
	input wire logic portBInputReady,
	input wire logic portBAlmostFullN,
	input wire logic portBAlmostEmptyN
);
	// previous clock levels; reset high so a clock high at release is no rise
	logic prevAQ;
	logic prevBQ;
	logic aRise;
	logic bRise;
	assign aRise = portAClock && !prevAQ;
	assign bRise = portBClock && !prevBQ;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prevAQ <= 1'b1;
			prevBQ <= 1'b1;
		end
		else
		begin
			prevAQ <= portAClock;
			prevBQ <= portBClock;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// an unqualified rise on one port while the other port stays still
	sequence sAIdle;
		aRise && !bRise ##0 (portAChipSelectN || !portAEnable);
	endsequence
	sequence sBIdle;
		bRise && !aRise ##0 (portBChipSelectN || !portBEnable);
	endsequence
	a_a_float_pins: assert property (
		portAChipSelectN |-> !portADataOe) else $error("port a drives");
	a_b_float_pins: assert property (
		portBChipSelectN |-> !portBDataOe) else $error("port b drives");
	a_a_flag_timing: assert property (
		!aRise |=> $stable({portAEmptyN, portAOutputReady, portAFullN,
		portAInputReady})) else $error("port a flag moved off rise");
	a_b_flag_timing: assert property (
		!bRise |=> $stable({portBEmptyN, portBOutputReady, portBFullN,
		portBInputReady, portBAlmostFullN, portBAlmostEmptyN}))
		else $error("b flag moved");
	a_b_data_timing: assert property (
		!bRise |=> $stable(portBDataOut)) else $error("b data moved");
	// only own writes fill a queue; a stale flag may still rise on a gated rise
	a_a_unqualified: assert property (
		sAIdle |=> !$fell(portAFullN)) else $error("a access not gated");
	a_b_unqualified: assert property (
		sBIdle |=> !$fell(portBFullN)) else $error("b access not gated");
	a_ready_full_same: assert property (
		portAInputReady == portAFullN) else $error("a ready differs");
	a_std_no_ready: assert property (
		endianTimingSelect |-> !portAOutputReady && !portBOutputReady)
		else $error("output ready in standard mode");
endmodule

bind bfp_port_ctrl bfp_port_ctrl_props u_props (.clk_sys, .rst_n,
	.endianTimingSelect, .portAClock, .portAChipSelectN, .portAEnable,
	.portADataOe, .portAEmptyN, .portAOutputReady, .portAFullN,
	.portAInputReady, .portBClock, .portBChipSelectN, .portBEnable,
	.portBDataOe, .portBDataOut, .portBEmptyN, .portBOutputReady,
	.portBFullN, .portBInputReady, .portBAlmostFullN, .portBAlmostEmptyN);

//--- sim/bfp_host_port.sv
`timescale 1ns/1ps
// host of one port: makes its clock and settles the shared data wire
module bfp_host_port #(
	parameter int LOW_CYC = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// host side of the wire
	input wire logic hostDrive,
	input wire logic [bfp_pkg::DATA_W-1:0] hostData,
	// device side of the wire
	input wire logic devOe,
	input wire logic [bfp_pkg::DATA_W-1:0] devData,
	// port clock, rise warning and resolved wire
	output logic portClock,
	output logic armed,
	output logic [bfp_pkg::DATA_W-1:0] wireData
);
	logic [3:0] cntQ;
	logic [bfp_pkg::DATA_W-1:0] lastQ;
	// next edge raises the clock, so the edge after it is the rise
	assign armed = !portClock && cntQ == 4'(LOW_CYC - 1);
	// a floating wire never keeps its value, so show the inverse
	assign wireData = devOe ? devData : hostDrive ? hostData : ~lastQ;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			portClock <= 1'b0;
			cntQ <= 4'h0;
			lastQ <= '0;
		end
		else
		begin
			lastQ <= wireData;
			portClock <= armed;
			cntQ <= (portClock || armed) ? 4'h0 : cntQ + 4'h1;
		end
	end
endmodule

//--- sim/bfp_port_ctrl_tb_top.sv
`timescale 1ns/1ps
module bfp_port_ctrl_tb_top;
	import bfp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic endianTimingSelect = TIMING_STD;
	// host controls, index 0 port a, 1 port b
	logic [1:0] csN = 2'h3;
	logic [1:0] en = 2'h0;
	logic [1:0] wr = 2'h0;
	logic [DATA_W-1:0] dat [2] = '{default: '0};
	wire [1:0] clkP;
	wire [1:0] armed;
	wire [1:0] oe;
	wire [DATA_W-1:0] wireD [2];
	wire [DATA_W-1:0] outD [2];
	wire aEmptyN, aReady, aFullN, aInReady, bEmptyN, bReady, bFullN;
	wire bInReady, bAfN, bAeN;
	int bad_count = 0;
	int check_count = 0;
	int k;
	logic [DATA_W-1:0] w;
	logic [DATA_W-1:0] expQ [$];
	always #2 clk_sys = ~clk_sys;
	bfp_host_port #(.LOW_CYC(1)) u_host_a (.clk_sys, .rst_n,
		.hostDrive(wr[0]), .hostData(dat[0]), .devOe(oe[0]),
		.devData(outD[0]), .portClock(clkP[0]), .armed(armed[0]),
		.wireData(wireD[0]));
	// slower b clock so rises drift against port a
	bfp_host_port #(.LOW_CYC(2)) u_host_b (.clk_sys, .rst_n,
		.hostDrive(wr[1]), .hostData(dat[1]), .devOe(oe[1]),
		.devData(outD[1]), .portClock(clkP[1]), .armed(armed[1]),
		.wireData(wireD[1]));
	bfp_port_ctrl u_dut (.clk_sys, .rst_n, .endianTimingSelect,
		.portAClock(clkP[0]), .portAChipSelectN(csN[0]),
		.portAEnable(en[0]), .portAWrite(wr[0]), .portADataIn(wireD[0]),
		.portADataOut(outD[0]), .portADataOe(oe[0]), .portAEmptyN(aEmptyN),
		.portAOutputReady(aReady), .portAFullN(aFullN),
		.portAInputReady(aInReady), .portBClock(clkP[1]),
		.portBChipSelectN(csN[1]), .portBEnable(en[1]), .portBWrite(wr[1]),
		.portBDataIn(wireD[1]), .portBDataOut(outD[1]), .portBDataOe(oe[1]),
		.portBEmptyN(bEmptyN), .portBOutputReady(bReady),
		.portBFullN(bFullN), .portBInputReady(bInReady),
		.portBAlmostFullN(bAfN), .portBAlmostEmptyN(bAeN));
	task automatic chk(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one access lined up with a rise of port p's clock
	task automatic acc(input int p, input logic c, e, r,
		input logic [DATA_W-1:0] d);
		do @(negedge clk_sys); while (!armed[p]);
		@(posedge clk_sys);
		csN[p] <= c;
		en[p] <= e;
		wr[p] <= r;
		dat[p] <= d;
		@(posedge clk_sys);
		csN[p] <= 1'b1;
		en[p] <= 1'b0;
		#1;
	endtask
	// expected level of a low-active flag: high unless the count sits at lim
	function automatic logic notAt(input int words, input int lim);
		return words != lim;
	endfunction
	task automatic restart(input logic strap);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		endianTimingSelect <= strap;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		k = $urandom(16);
		restart(TIMING_STD);
		chk("aEmptyN", aEmptyN, RST_EMPTY_N);
		chk("aFullN", aFullN, RST_FULL_N);
		// random fill of a_to_b, gated-off accesses mixed in
		while (expQ.size() < QUEUE_DEPTH)
		begin
			w = DATA_W'({$urandom, $urandom});
			k = $urandom_range(3);
			acc(0, k == 1, k != 2, 1'b1, w);
			if (k == 0 || k == 3)
				expQ.push_back(w);
		end
		chk("aFullN", aFullN, notAt(expQ.size(), QUEUE_DEPTH));
		acc(0, 0, 1, 1, '1);
		acc(1, 1, 1, 0, 0);
		chk("bEmptyN", bEmptyN, 1);
		chk("bAeN", bAeN, 1);
		// b_to_a traffic read back on port a
		for (int i = 0; i < 3; i++)
			acc(1, 0, 1, 1, DATA_W'(i + 5));
		chk("bFullN", bFullN, 1);
		chk("bAfN", bAfN, 1);
		for (int i = 0; i < 3; i++)
		begin
			acc(0, 0, 1, 0, 0);
			chk("aOut", outD[0], DATA_W'(i + 5));
			chk("aEmptyN", aEmptyN, notAt(2 - i, 0));
		end
		// drain past empty: the refused read leaves data standing
		while (expQ.size() > 0)
		begin
			w = expQ.pop_front();
			acc(1, 0, 1, 0, 0);
			chk("bOut", outD[1], w);
		end
		acc(1, 0, 1, 0, 0);
		chk("bOut", outD[1], w);
		chk("bEmptyN", bEmptyN, notAt(expQ.size(), 0));
		chk("bAeN", bAeN, 0);
		// fall-through: strap static from reset on
		restart(~TIMING_STD);
		for (int i = 0; i < 2; i++)
			acc(0, 0, 1, 1, DATA_W'(i + 9));
		acc(1, 0, 1, 1, DATA_W'(7));
		acc(1, 1, 1, 0, 0);
		acc(0, 1, 1, 0, 0);
		chk("aReady", aReady, 1);
		chk("aOut", outD[0], DATA_W'(7));
		chk("aInReady", aInReady, 1);
		chk("bInReady", bInReady, 1);
		chk("bReady", bReady, 1);
		chk("bOut", outD[1], DATA_W'(9));
		acc(1, 0, 1, 0, 0);
		chk("bOut", outD[1], DATA_W'(10));
		acc(1, 0, 1, 0, 0);
		chk("bReady", bReady, 0);
		stop_test;
	end
	// watchdog well beyond the expected run
	initial
	begin
		#100000;
		bad_count++;
		stop_test;
	end
endmodule
